// file: common/pmu_filter_pkg.sv
// Constants and carrier types for the monitor filter register bank.
// Assumes one clock domain; every user imports the whole package.
package pmu_filter_pkg;

    // Privilege level code
    typedef logic [1:0] priv_t;
    localparam priv_t PL0 = 2'h0;
    localparam priv_t PL1 = 2'h1;
    localparam priv_t PL2 = 2'h2;
    localparam priv_t PL3 = 2'h3;

    // Coprocessor encoding shared by all bank registers
    localparam logic [3:0] COPROC_NUM = 4'hF;
    localparam logic [2:0] OPC1_NUM   = 3'h0;
    localparam logic [3:0] CRN_CFG    = 4'hE;
    // Cycle filter direct encoding
    localparam logic [3:0] CRM_CYC    = 4'hF;
    localparam logic [2:0] OPC2_CYC   = 3'h7;
    // Event-type direct encoding, top bits of CRm
    localparam logic [1:0] CRM_EVT_HI = 2'h3;
    // Indirect window encoding
    localparam logic [3:0] CRN_WIN    = 4'h9;
    localparam logic [3:0] CRM_WIN    = 4'hD;
    localparam logic [2:0] OPC2_WIN   = 3'h1;
    // Selector value that aliases the cycle filter
    localparam logic [4:0] SEL_CYCLE  = 5'h1F;

    // Trap syndrome for coprocessor accesses
    localparam logic [5:0] SYND_TRAP  = 6'h03;
    // Cycles from request edge to answer
    localparam int ANSWER_CYCLES = 1;

    // Field positions
    localparam int BIT_P   = 31;
    localparam int BIT_U   = 30;
    localparam int BIT_NS_KERN = 29;
    localparam int BIT_NS_USER = 28;
    localparam int BIT_HYP     = 27;
    localparam int BIT_MTHR    = 25;
    localparam int BIT_REALM_U = 21;
    localparam int EVT_NUM_W = 10;

    // Storable field masks and the reserved-bit mask
    localparam logic [31:0] MASK_PU   = 32'hC000_0000;
    localparam logic [31:0] MASK_EVT  = 32'h0000_03FF;
    localparam logic [31:0] MASK_NS   = 32'h3000_0000;
    localparam logic [31:0] MASK_HYP  = 32'h0800_0000;
    localparam logic [31:0] MASK_MTHR    = 32'h0200_0000;
    localparam logic [31:0] MASK_REALM_U = 32'h0020_0000;
    localparam logic [31:0] MASK_RSVD = 32'h05C0_0000;

    // Values after reset
    localparam logic [31:0] EVT_RESET = 32'h0000_0000;
    localparam logic [31:0] CYC_RESET = 32'h0000_0000;

    // Outcome of the access checks
    typedef enum {OUT_ACCESS, OUT_UNDEF, OUT_TRAP} outcome_e;

    // Coprocessor access request
    typedef struct packed {
        logic        valid;
        logic        write;
        logic [3:0]  coproc;
        logic [2:0]  opc1;
        logic [3:0]  crn;
        logic [3:0]  crm;
        logic [2:0]  opc2;
        logic [31:0] wdata;
    } acc_req_s;

    // Answer to an access
    typedef struct packed {
        logic        done;
        logic        undef;
        logic        trap;
        priv_t       target;
        logic [5:0]  syndrome;
        logic [31:0] rdata;
    } acc_resp_s;

    // Trap controls held elsewhere in the processor
    typedef struct packed {
        priv_t      level;
        logic       halted;
        logic       secure_debug_disabled;
        logic       user_access_enable;
        logic       lvl2_enabled;
        logic       host_hyp_mode;
        logic       trap_general_exceptions;
        logic       hyp_monitor_trap;
        logic       secure_monitor_trap;
        logic       fine_grain_trap_enable;
        logic       fg_read_cyc;
        logic       fg_write_cyc;
        logic       fg_read_evt;
        logic       fg_write_evt;
        logic [4:0] counter_select_field;
    } trap_ctrl_s;

    // Context of the event being counted
    typedef struct packed {
        priv_t level;
        logic  nonsecure;
        logic  realm;
        logic  mthread_enable;
    } exec_ctx_s;

endpackage

// file: logic/evt_filter_eval.sv
// Filter evaluation for one event-type or cycle filter value.
// Assumes the value is already masked to implemented fields.
`timescale 1ns/1ps
module evt_filter_eval
    import pmu_filter_pkg::*;
#(
    parameter bit HAS_LVL2  = 1'b1,
    parameter bit HAS_LVL3  = 1'b1,
    parameter bit HAS_REALM = 1'b1,
    parameter bit HAS_MTHR  = 1'b1
)(
    // Filter value and counting context
    input  wire logic [31:0]          cfg_in,
    input  wire exec_ctx_s            ctx_in,
    // Results
    output logic                      count_ok_out,
    output logic                      any_pe_out,
    output logic [EVT_NUM_W-1:0]      event_num_out
);

    // Level filter decision
    always_comb begin
        unique case (ctx_in.level)
            PL0: begin
                // Realm user filter must match plain user filter
                if (HAS_REALM && ctx_in.realm) begin
                    count_ok_out = cfg_in[BIT_REALM_U] == cfg_in[BIT_U];
                end else if (HAS_LVL3 && ctx_in.nonsecure) begin
                    count_ok_out = cfg_in[BIT_NS_USER] == cfg_in[BIT_U];
                end else begin
                    count_ok_out = !cfg_in[BIT_U];
                end
            end
            PL1: begin
                // Nonsecure kernel filter must match privileged
                if (HAS_LVL3 && ctx_in.nonsecure) begin
                    count_ok_out = cfg_in[BIT_NS_KERN] == cfg_in[BIT_P];
                end else begin
                    count_ok_out = !cfg_in[BIT_P];
                end
            end
            // Hyp level counts only when enabled
            PL2: count_ok_out = HAS_LVL2 && cfg_in[BIT_HYP];
            // Top level follows the privileged filter
            PL3: count_ok_out = !cfg_in[BIT_P];
        endcase
    end

    // Shared-affinity counting only when feature enabled
    assign any_pe_out = HAS_MTHR && ctx_in.mthread_enable
                        && cfg_in[BIT_MTHR];

    // Event number passes straight through
    assign event_num_out = cfg_in[EVT_NUM_W-1:0];

endmodule

// file: logic/pmu_event_filter_config.sv
// Monitor filter register bank: cycle filter, event-type registers.
// Assumes requests are synchronous to clk_in and controls are stable.
// Function
// - Selector all-ones aliases cycle filter through window
// - Cycle filter decodes at fixed coprocessor encoding
// - User access disabled traps to level two or one
// - Halted secure-debug monitor trap at level zero is undefined first
// - Fine-grain read bit traps reads to level two
// - Fine-grain write bit traps writes to level two
// - Hyp monitor trap sends access to level two
// - Secure monitor trap: undefined halted with secure debug disabled, else level three
// - One event-type register per counter, zero to thirty
// - Registers absent without both features: undefined
// - Privileged filter bit gates level one counting
// - User filter bit gates level zero counting
// - Nonsecure kernel bit must equal privileged bit
// - Nonsecure user bit must equal user bit
// - Hyp filter bit set enables level two counting
// - Multithread bit widens counting to sibling elements
// - Disabled multithread feature forces the bit off
// - Warm reset leaves filter fields with no defined value; here reset loads them with zero
// - Realm user filter also controls realm level zero
// - Realm level zero counts when realm bit equals user
// - Low ten bits select the counted event number
`timescale 1ns/1ps
module pmu_event_filter_config
    import pmu_filter_pkg::*;
#(
    parameter int NUM_COUNTERS = 31,
    parameter bit HAS_AA32     = 1'b1,
    parameter bit HAS_PMU      = 1'b1,
    parameter bit HAS_LVL2     = 1'b1,
    parameter bit HAS_LVL3     = 1'b1,
    parameter bit HAS_FGT      = 1'b1,
    parameter bit HAS_MTHR     = 1'b1,
    parameter bit HAS_REALM    = 1'b1,
    parameter bit DBG_PRIO_OPT = 1'b1
)(
    // Clock and reset
    input  wire logic                 clk_in,
    input  wire logic                 rstn_in,
    // Access request, trap controls, answer
    input  wire acc_req_s             req_in,
    input  wire trap_ctrl_s           ctrl_in,
    output acc_resp_s                 resp_out,
    // Counting context
    input  wire exec_ctx_s            ctx_in,
    // Filter results per event counter
    output logic [NUM_COUNTERS-1:0]   count_ok_out,
    output logic [NUM_COUNTERS-1:0]   any_pe_out,
    output logic [NUM_COUNTERS-1:0][EVT_NUM_W-1:0] event_num_out,
    // Filter result for the cycle counter
    output logic                      cycle_ok_out
);

    // Counter count must fit the five-bit index
    if (NUM_COUNTERS < 1 || NUM_COUNTERS > 31) begin : g_bad_num
        $error("NUM_COUNTERS must lie in 1 to 31");
    end

    // Bank present only with both features
    localparam bit PRESENT = HAS_AA32 && HAS_PMU;
    // Storable bits of an event-type register
    localparam logic [31:0] EVT_MASK = MASK_PU | MASK_EVT
        | (HAS_LVL3 ? MASK_NS : 32'h0000_0000)
        | (HAS_LVL2 ? MASK_HYP : 32'h0000_0000)
        | (HAS_MTHR ? MASK_MTHR : 32'h0000_0000)
        | (HAS_REALM ? MASK_REALM_U : 32'h0000_0000);
    // Storable bits of the cycle filter
    localparam logic [31:0] CYC_MASK = EVT_MASK & ~MASK_EVT & ~MASK_MTHR;

    // Whole module state
    typedef struct packed {
        logic [NUM_COUNTERS-1:0][31:0] evt;
        logic [31:0]                   cyc;
        acc_resp_s                     resp;
    } state_s;

    state_s   state_q;      // Registered state
    state_s   state_d;      // Next state

    // Decode and check signals
    logic     base_hit;     // Coprocessor and opc1 match
    logic     cyc_direct;   // Direct cycle filter encoding
    logic     evt_direct;   // Direct event-type encoding
    logic     win_hit;      // Indirect window encoding
    logic [4:0] idx;        // Selected register index
    logic     tgt_cyc;      // Access lands on cycle filter
    logic     tgt_evt;      // Access lands on event-type
    logic     idx_bad;      // Index beyond implemented counters
    logic     lvl2_on;      // Level two present and enabled
    logic     fg_bit;       // Fine-grain bit for this access
    logic     fg_trap;      // Fine-grain trap fires
    logic     dbg_undef;    // Halted priority undefined case
    outcome_e outcome;      // Result of the checks
    priv_t    target;       // Trap target level

    // Encoding decode
    always_comb begin
        base_hit   = req_in.valid && req_in.coproc == COPROC_NUM
                     && req_in.opc1 == OPC1_NUM;
        cyc_direct = base_hit && req_in.crn == CRN_CFG
                     && req_in.crm == CRM_CYC
                     && req_in.opc2 == OPC2_CYC;
        evt_direct = base_hit && req_in.crn == CRN_CFG
                     && req_in.crm[3:2] == CRM_EVT_HI && !cyc_direct;
        win_hit    = base_hit && req_in.crn == CRN_WIN
                     && req_in.crm == CRM_WIN
                     && req_in.opc2 == OPC2_WIN;
        // Window uses selector, direct uses CRm and opc2
        if (win_hit) begin
            idx = ctrl_in.counter_select_field;
        end else begin
            idx = {req_in.crm[1:0], req_in.opc2};
        end
        tgt_cyc = cyc_direct
                  || (win_hit && idx == SEL_CYCLE);
        tgt_evt = !tgt_cyc && (evt_direct || win_hit);
        idx_bad = tgt_evt && idx >= 5'(NUM_COUNTERS);
    end

    // Trap and undefined checks in priority order
    always_comb begin
        lvl2_on   = HAS_LVL2 && ctrl_in.lvl2_enabled;
        // Pick the fine-grain bit by register and direction
        if (tgt_cyc) begin
            fg_bit = req_in.write ? ctrl_in.fg_write_cyc
                                  : ctrl_in.fg_read_cyc;
        end else begin
            fg_bit = req_in.write ? ctrl_in.fg_write_evt
                                  : ctrl_in.fg_read_evt;
        end
        fg_trap   = lvl2_on
                    && !(ctrl_in.host_hyp_mode
                         && ctrl_in.trap_general_exceptions)
                    && HAS_FGT
                    && (!HAS_LVL3 || ctrl_in.fine_grain_trap_enable)
                    && fg_bit;
        dbg_undef = ctrl_in.halted && HAS_LVL3
                    && ctrl_in.secure_debug_disabled && DBG_PRIO_OPT
                    && ctrl_in.secure_monitor_trap;
        outcome   = OUT_ACCESS;
        target    = PL1;
        if (!PRESENT || idx_bad) begin
            // Absent bank or unimplemented counter
            outcome = OUT_UNDEF;
        end else if (ctrl_in.level == PL0 && dbg_undef) begin
            // Halted debug case wins over all but absent bank or unimplemented counter
            outcome = OUT_UNDEF;
        end else if (ctrl_in.level == PL0
                     && !ctrl_in.user_access_enable) begin
            // User access disabled
            outcome = OUT_TRAP;
            if (lvl2_on && ctrl_in.trap_general_exceptions) begin
                target = PL2;
            end
        end else if (fg_trap) begin
            // Fine-grain trap
            outcome = OUT_TRAP;
            target  = PL2;
        end else if (lvl2_on && ctrl_in.hyp_monitor_trap) begin
            // Hyp monitor trap
            outcome = OUT_TRAP;
            target  = PL2;
        end else if (HAS_LVL3 && ctrl_in.secure_monitor_trap) begin
            // Secure monitor trap
            if (ctrl_in.halted && ctrl_in.secure_debug_disabled) begin
                outcome = OUT_UNDEF;
            end else begin
                outcome = OUT_TRAP;
                target  = PL3;
            end
        end
    end

    // Next-state logic
    always_comb begin
        state_d      = state_q;
        // Answer is a one-cycle pulse
        state_d.resp = '0;
        if (tgt_cyc || tgt_evt) begin
            state_d.resp.done = 1'b1;
            unique case (outcome)
                OUT_UNDEF: state_d.resp.undef = 1'b1;
                OUT_TRAP: begin
                    state_d.resp.trap     = 1'b1;
                    state_d.resp.target   = target;
                    state_d.resp.syndrome = SYND_TRAP;
                end
                OUT_ACCESS: begin
                    // Read returns, write stores masked value
                    if (tgt_cyc && req_in.write) begin
                        state_d.cyc = req_in.wdata & CYC_MASK;
                    end else if (tgt_cyc) begin
                        state_d.resp.rdata = state_q.cyc;
                    end else if (req_in.write) begin
                        state_d.evt[idx] = req_in.wdata
                                           & EVT_MASK;
                    end else begin
                        state_d.resp.rdata = state_q.evt[idx];
                    end
                end
            endcase
        end
    end

    // State register; reset loads EVT_RESET and CYC_RESET into the filter fields
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            state_q.evt  <= {NUM_COUNTERS{EVT_RESET}};
            state_q.cyc  <= CYC_RESET;
            state_q.resp <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    assign resp_out = state_q.resp;

    // One filter evaluator per event counter
    for (genvar i = 0; i < NUM_COUNTERS; i++) begin : g_evt
        evt_filter_eval #(
            .HAS_LVL2  (HAS_LVL2),
            .HAS_LVL3  (HAS_LVL3),
            .HAS_REALM (HAS_REALM),
            .HAS_MTHR  (HAS_MTHR)
        ) u_eval (
            .cfg_in        (state_q.evt[i]),
            .ctx_in        (ctx_in),
            .count_ok_out  (count_ok_out[i]),
            .any_pe_out    (any_pe_out[i]),
            .event_num_out (event_num_out[i])
        );
    end

    // Cycle filter evaluator, no multithread bit
    evt_filter_eval #(
        .HAS_LVL2  (HAS_LVL2),
        .HAS_LVL3  (HAS_LVL3),
        .HAS_REALM (HAS_REALM),
        .HAS_MTHR  (1'b0)
    ) u_cyc_eval (
        .cfg_in        (state_q.cyc),
        .ctx_in        (ctx_in),
        .count_ok_out  (cycle_ok_out),
        .any_pe_out    (),
        .event_num_out ()
    );

    // Checks on the answer and state
    absent_undef_a: assert property (
        @(posedge clk_in) disable iff (!rstn_in)
        (!PRESENT && (tgt_cyc || tgt_evt))
        |=> resp_out.done && resp_out.undef && !resp_out.trap)
        else $error("absent bank access not undefined");

    user_trap_a: assert property (
        @(posedge clk_in) disable iff (!rstn_in)
        (PRESENT && tgt_cyc && ctrl_in.level == PL0 && !dbg_undef
         && !ctrl_in.user_access_enable)
        |=> resp_out.trap && resp_out.syndrome == 6'h03
            && resp_out.target == ($past(lvl2_on
                && ctrl_in.trap_general_exceptions) ? PL2 : PL1))
        else $error("user access trap wrong");

    debug_undef_a: assert property (
        @(posedge clk_in) disable iff (!rstn_in)
        (PRESENT && !idx_bad && (tgt_cyc || tgt_evt)
         && ctrl_in.level == PL0 && dbg_undef)
        |=> resp_out.undef && !resp_out.trap)
        else $error("halted debug access not undefined");

    fg_read_a: assert property (
        @(posedge clk_in) disable iff (!rstn_in)
        (PRESENT && tgt_cyc && !req_in.write && ctrl_in.level == PL1
         && lvl2_on && HAS_FGT && ctrl_in.fine_grain_trap_enable
         && !ctrl_in.host_hyp_mode && ctrl_in.fg_read_cyc)
        |=> resp_out.trap && resp_out.target == PL2
            && resp_out.syndrome == 6'h03)
        else $error("fine-grain read trap missing");

    fg_write_a: assert property (
        @(posedge clk_in) disable iff (!rstn_in)
        (PRESENT && tgt_cyc && req_in.write && ctrl_in.level == PL1
         && lvl2_on && HAS_FGT && ctrl_in.fine_grain_trap_enable
         && !ctrl_in.host_hyp_mode && ctrl_in.fg_write_cyc)
        |=> resp_out.trap && resp_out.target == PL2
            && $stable(state_q.cyc))
        else $error("fine-grain write trap missing");

    hyp_trap_a: assert property (
        @(posedge clk_in) disable iff (!rstn_in)
        (PRESENT && tgt_cyc && ctrl_in.level == PL1 && !fg_trap
         && lvl2_on && ctrl_in.hyp_monitor_trap)
        |=> resp_out.trap && resp_out.target == PL2)
        else $error("hyp monitor trap missing");

    mon_trap_a: assert property (
        @(posedge clk_in) disable iff (!rstn_in)
        (PRESENT && tgt_cyc && ctrl_in.level == PL1 && !fg_trap
         && !(lvl2_on && ctrl_in.hyp_monitor_trap) && HAS_LVL3
         && ctrl_in.secure_monitor_trap && !ctrl_in.halted)
        |=> resp_out.trap && resp_out.target == PL3)
        else $error("secure monitor trap missing");

    window_alias_a: assert property (
        @(posedge clk_in) disable iff (!rstn_in)
        (win_hit && ctrl_in.counter_select_field == 5'h1F
         && req_in.write && outcome == OUT_ACCESS)
        |=> state_q.cyc == ($past(req_in.wdata) & CYC_MASK))
        else $error("window alias write lost");

    reserved_zero_a: assert property (
        @(posedge clk_in) disable iff (!rstn_in)
        (tgt_evt && req_in.write && outcome == OUT_ACCESS)
        |=> (state_q.evt[$past(idx)] & MASK_RSVD) == 32'h0000_0000)
        else $error("reserved bits stored");

    multithread_off_a: assert property (
        @(posedge clk_in) disable iff (!rstn_in)
        !ctx_in.mthread_enable |-> any_pe_out == '0)
        else $error("disabled multithread bit honoured");

endmodule

// file: tb/test_pmu_event_filter_config.sv
// Self-checking bench for the monitor filter register bank.
// Assumes the bank's default parameters: all features, 31 counters.
`timescale 1ns/1ps
`define CHK(nm, exp, got) \
    compares++; \
    if ((got) !== (exp)) begin \
        $display("Error %s expected %h seen %h", nm, exp, got); \
        fail_count++; \
    end
module test_pmu_event_filter_config;
    import pmu_filter_pkg::*;
    // Clock, reset and stimulus
    logic                   clk_in;
    logic                   rstn_in;
    acc_req_s               req_in;
    trap_ctrl_s             ctrl_in;
    exec_ctx_s              ctx_in;
    // Observed outputs
    acc_resp_s              resp_out;
    logic [30:0]            count_ok_out;
    logic [30:0]            any_pe_out;
    logic [30:0][9:0]       event_num_out;
    logic                   cycle_ok_out;
    // Bookkeeping
    int                     fail_count;
    int                     compares;
    acc_resp_s              rsp;
    logic [31:0]            cyc_exp;
    // Stored bits of an event-type register
    localparam logic [31:0] EVT_MASK = 32'hFA20_03FF;

    pmu_event_filter_config u_dut (
        .clk_in        (clk_in),
        .rstn_in       (rstn_in),
        .req_in        (req_in),
        .ctrl_in       (ctrl_in),
        .resp_out      (resp_out),
        .ctx_in        (ctx_in),
        .count_ok_out  (count_ok_out),
        .any_pe_out    (any_pe_out),
        .event_num_out (event_num_out),
        .cycle_ok_out  (cycle_ok_out)
    );

    // Free-running clock, 5 ns period
    initial begin
        clk_in = 1'b0;
        forever #2.5 clk_in = ~clk_in;
    end

    // Trap controls from a level and thirteen flags
    function automatic trap_ctrl_s mk(priv_t lv, logic [12:0] f);
        return trap_ctrl_s'({lv, f, 5'h00});
    endfunction

    // One request pulse; answer captured one cycle later
    task automatic acc(input logic wr, input logic [3:0] crn, crm,
                       input logic [2:0] opc2, input logic [31:0] wd);
        @(posedge clk_in);
        #1;
        req_in = '{1'b1, wr, COPROC_NUM, OPC1_NUM, crn, crm, opc2, wd};
        @(posedge clk_in);
        #1;
        req_in.valid = 1'b0;
        rsp = resp_out;
    endtask

    // Cycle filter access under given controls, answer checked
    task automatic trap_case(input priv_t lv, input logic [12:0] f,
                             input logic wr, un, tr, input priv_t tg);
        logic [31:0] wd;
        wd = (un | tr) ? 32'hFFFF_FFFF : 32'hC000_0000;
        ctrl_in = mk(lv, f);
        acc(wr, CRN_CFG, CRM_CYC, OPC2_CYC, wd);
        `CHK("done", 1'b1, rsp.done)
        `CHK("undef", un, rsp.undef)
        `CHK("trap", tr, rsp.trap)
        if (tr) begin
            `CHK("target", tg, rsp.target)
            `CHK("syndrome", SYND_TRAP, rsp.syndrome)
        end
        if (!un && !tr && wr)
            cyc_exp = wd;
        if (!un && !tr && !wr) begin
            `CHK("cycle rdata", cyc_exp, rsp.rdata)
        end
    endtask

    // Program counter 0, then look at its filter result
    task automatic flt(input logic [31:0] wd, input exec_ctx_s c,
                       input logic ok, any);
        ctrl_in = mk(PL1, 13'h0410);
        acc(1'b1, CRN_CFG, 4'hC, 3'h0, wd);
        ctx_in = c;
        #1;
        `CHK("count ok", ok, count_ok_out[0])
        `CHK("any pe", any, any_pe_out[0])
    endtask

    // Verdict and end of run
    task automatic summarize();
        $display("Comparisons %0d, mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // Watchdog against a hung run
    initial begin
        #50000;
        fail_count++;
        summarize();
    end

    // Main sequence
    initial begin
        fail_count = 0;
        compares   = 0;
        cyc_exp    = CYC_RESET;
        rstn_in    = 1'b0;
        req_in     = '0;
        ctrl_in    = mk(PL1, 13'h0410);
        ctx_in     = '0;
        repeat (6) @(posedge clk_in);
        #1;
        rstn_in = 1'b1;
        // Reset values read back
        acc(1'b0, CRN_CFG, 4'hC, 3'h7, 32'h0000_0000);
        `CHK("evt7 reset", EVT_RESET, rsp.rdata)
        acc(1'b0, CRN_CFG, CRM_CYC, OPC2_CYC, 32'h0000_0000);
        `CHK("cyc reset", CYC_RESET, rsp.rdata)
        // Every counter register written, then read back
        for (int i = 0; i < 31; i++) begin
            acc(1'b1, CRN_CFG, {2'h3, 2'(i >> 3)}, 3'(i), 32'hFFFF_FFFF ^ i);
        end
        for (int i = 0; i < 31; i++) begin
            acc(1'b0, CRN_CFG, {2'h3, 2'(i >> 3)}, 3'(i), 32'h0000_0000);
            `CHK("evt rdata", (32'hFFFF_FFFF ^ i) & EVT_MASK, rsp.rdata)
            `CHK("evt num", 10'(32'h3FF ^ i), event_num_out[i])
        end
        // Window reaches counter 2 and, with all-ones, the cycle filter
        ctrl_in.counter_select_field = 5'h02;
        acc(1'b0, CRN_WIN, CRM_WIN, OPC2_WIN, 32'h0000_0000);
        `CHK("win evt2", 32'hFFFF_FFFD & EVT_MASK, rsp.rdata)
        ctrl_in.counter_select_field = SEL_CYCLE;
        acc(1'b1, CRN_WIN, CRM_WIN, OPC2_WIN, 32'h8000_0000);
        acc(1'b0, CRN_CFG, CRM_CYC, OPC2_CYC, 32'h0000_0000);
        `CHK("win cycle", 32'h8000_0000, rsp.rdata)
        cyc_exp = 32'h8000_0000;
        // Foreign encoding gets no answer
        acc(1'b0, 4'h3, CRM_CYC, OPC2_CYC, 32'h0000_0000);
        `CHK("refused", 1'b0, rsp.done)
        // Flags: hlt sdis uae lv2 hhm tgen hmt smt fgte frc fwc fre fwe
        trap_case(PL0, 13'b1_1_1_0_0_0_0_1_1_0_0_0_0, 0, 1, 0, PL0);
        trap_case(PL0, 13'b0_0_0_0_0_0_0_0_1_0_0_0_0, 0, 0, 1, PL1);
        trap_case(PL0, 13'b0_0_0_1_0_1_0_0_1_0_0_0_0, 0, 0, 1, PL2);
        trap_case(PL1, 13'b0_0_1_1_0_0_0_0_1_1_0_0_0, 0, 0, 1, PL2);
        trap_case(PL1, 13'b0_0_1_1_1_1_0_0_1_1_0_0_0, 0, 0, 0, PL0);
        trap_case(PL1, 13'b0_0_1_1_0_0_0_0_0_1_0_0_0, 0, 0, 0, PL0);
        trap_case(PL1, 13'b0_0_1_1_0_0_0_0_1_1_0_0_0, 1, 0, 0, PL0);
        trap_case(PL1, 13'b0_0_1_1_0_0_0_0_1_0_1_0_0, 1, 0, 1, PL2);
        trap_case(PL1, 13'b0_0_1_1_0_0_1_0_1_0_0_0_0, 0, 0, 1, PL2);
        trap_case(PL1, 13'b1_1_1_0_0_0_0_1_1_0_0_0_0, 1, 1, 0, PL0);
        trap_case(PL1, 13'b0_0_1_0_0_0_0_1_1_0_0_0_0, 1, 0, 1, PL3);
        trap_case(PL1, 13'b0_0_1_0_0_0_0_0_1_0_0_0_0, 0, 0, 0, PL0);
        // Counting filters of counter 0; ctx: level, ns, realm, multithread
        flt(32'h8000_0000, exec_ctx_s'({PL1, 3'b000}), 0, 0);
        flt(32'h0000_0000, exec_ctx_s'({PL1, 3'b000}), 1, 0);
        flt(32'h4000_0000, exec_ctx_s'({PL0, 3'b000}), 0, 0);
        flt(32'h2000_0000, exec_ctx_s'({PL1, 3'b100}), 0, 0);
        flt(32'hA000_0000, exec_ctx_s'({PL1, 3'b100}), 1, 0);
        flt(32'h1000_0000, exec_ctx_s'({PL0, 3'b100}), 0, 0);
        flt(32'h0800_0000, exec_ctx_s'({PL2, 3'b000}), 1, 0);
        flt(32'h0000_0000, exec_ctx_s'({PL2, 3'b000}), 0, 0);
        flt(32'h0020_0000, exec_ctx_s'({PL0, 3'b010}), 0, 0);
        flt(32'h4020_0000, exec_ctx_s'({PL0, 3'b010}), 1, 0);
        flt(32'h0200_0000, exec_ctx_s'({PL1, 3'b001}), 1, 1);
        flt(32'h0200_0000, exec_ctx_s'({PL1, 3'b000}), 1, 0);
        // Cycle filter result before and after a write
        `CHK("cycle ok", 1'b0, cycle_ok_out)
        acc(1'b1, CRN_CFG, CRM_CYC, OPC2_CYC, 32'h0800_0000);
        ctx_in = exec_ctx_s'({PL2, 3'b000});
        #1;
        `CHK("cycle ok", 1'b1, cycle_ok_out)
        summarize();
    end
endmodule
